//--- hdl/wwt_pkg.sv
// windowed watchdog timer: shared constants, register map and state types
// assumes one 200 MHz clock; one aclk cycle counts as one cpu machine cycle
package wwt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS      = 5;
  localparam int unsigned PRESCALE_CYCLES    = 16000;
  localparam int unsigned PIN_LOW_NS         = 30000;
  // a typical figure, so the plain quotient is used
  localparam int unsigned PIN_LOW_CYCLES     = PIN_LOW_NS / CLK_PERIOD_NS;
  localparam int unsigned PHASE_SHORT_CYCLES = 256;
  localparam int unsigned PHASE_LONG_CYCLES  = 4096;
  localparam int          TIMER_W            = 16;

  ////////////////////////////////////////////////////////////////////////////
  // register map: printed offsets are indices, byte address is index * 4
  localparam int          AXI_ADDR_W    = 8;
  localparam int          AXI_DATA_W    = 32;
  localparam logic [5:0]  CTRL_INDEX    = 6'h33;
  localparam logic [5:0]  STATUS_INDEX  = 6'h34;
  localparam logic [7:0]  CTRL_RESET    = 8'h7F;
  localparam int          ACTIVE_BIT    = 7;
  localparam int          COUNT_MSB_BIT = 6;
  localparam int          COUNT_W       = 7;
  localparam logic [6:0]  COUNT_TRIP    = 7'h40;
  localparam int          ST_ACTIVE_BIT = 0;
  localparam int          ST_HW_BIT     = 1;
  localparam int          ST_HALT_BIT   = 2;
  localparam int          ST_BUSY_BIT   = 3;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // reset sequence
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_PIN   = 2'b01,
    SEQ_PHASE = 2'b10
  } wwt_seq_t;

endpackage : wwt_pkg

//--- hdl/wwt_prescaler.sv
// free-running prescaler: one-cycle tick every DIV clock cycles
// assumes DIV fits the package timer width and is at least 2
`timescale 1ns/10ps
module wwt_prescaler
  import wwt_pkg::*;
#(
  parameter int unsigned DIV = PRESCALE_CYCLES
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      tick
);

  logic [TIMER_W-1:0] cnt_reg;
  logic [TIMER_W-1:0] cnt_next;
  logic               tick_next;
  logic               tick_reg;

  always_comb begin
    tick_next = (cnt_reg == TIMER_W'(DIV - 1));
    cnt_next  = tick_next ? '0 : cnt_reg + TIMER_W'(1);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule : wwt_prescaler

//--- hdl/wwt_timer.sv
// one-shot down timer: load starts it, busy stays high for len cycles,
// done pulses in the last busy cycle
// assumes len is never zero when load is raised
`timescale 1ns/10ps
module wwt_timer
  import wwt_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               load,
  input  wire logic [TIMER_W-1:0] len,
  output logic                    busy,
  output logic                    done
);

  logic [TIMER_W-1:0] left_reg;
  logic [TIMER_W-1:0] left_next;

  always_comb begin
    left_next = left_reg;
    if (load) begin
      left_next = len;
    end else if (left_reg != '0) begin
      left_next = left_reg - TIMER_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_reg <= '0;
    end else begin
      left_reg <= left_next;
    end
  end

  assign busy = (left_reg != '0);
  assign done = (left_reg == TIMER_W'(1));

endmodule : wwt_timer

//--- hdl/wwt_top.sv
// windowed watchdog timer: control register, count field, reset sequencer
// assumes an AXI4-Lite master on the same clock, option bits static while
// running, and a system that re-asserts aresetn from the reset outputs
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/10ps
module wwt_top
  import wwt_pkg::*;
#(
  parameter int unsigned PRESCALE = PRESCALE_CYCLES,
  parameter int unsigned PIN_LOW  = PIN_LOW_CYCLES
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [AXI_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [AXI_DATA_W-1:0]   s_axi_wdata,
  input  wire logic [AXI_DATA_W/8-1:0] s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [AXI_DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    hw_watchdog_option,
  input  wire logic                    halt_reset_option,
  input  wire logic                    long_reset_phase,
  input  wire logic                    halt_request,
  output logic                         halt_enter,
  output logic                         reset_pin_out,
  output logic                         reset_pin_oe,
  output logic                         reset_phase
);

  ////////////////////////////////////////////////////////////////////////////
  // bus write channel: address and data are caught independently

  logic [AXI_ADDR_W-1:0] awaddr_reg;
  logic [AXI_ADDR_W-1:0] awaddr_next;
  logic                  aw_full_reg;
  logic                  aw_full_next;
  logic [7:0]            wbyte_reg;
  logic [7:0]            wbyte_next;
  logic                  wlane_reg;
  logic                  wlane_next;
  logic                  w_full_reg;
  logic                  w_full_next;
  logic                  bvalid_reg;
  logic                  bvalid_next;
  logic [1:0]            bresp_reg;
  logic [1:0]            bresp_next;
  logic                  wr_fire;
  logic                  wr_ctrl;

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready  = !w_full_reg;
  assign wr_fire       = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_ctrl       = wr_fire && (awaddr_reg[AXI_ADDR_W-1:2] == CTRL_INDEX) && wlane_reg;

  always_comb begin
    awaddr_next  = awaddr_reg;
    aw_full_next = aw_full_reg;
    wbyte_next   = wbyte_reg;
    wlane_next   = wlane_reg;
    w_full_next  = w_full_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (s_axi_awvalid && !aw_full_reg) begin
      awaddr_next  = s_axi_awaddr;
      aw_full_next = 1'b1;
    end
    if (s_axi_wvalid && !w_full_reg) begin
      wbyte_next  = s_axi_wdata[7:0];
      wlane_next  = s_axi_wstrb[0];
      w_full_next = 1'b1;
    end
    if (wr_fire) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      // the status word is read-only, so only the control index answers okay
      bresp_next   = (awaddr_reg[AXI_ADDR_W-1:2] == CTRL_INDEX) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg  <= '0;
      aw_full_reg <= 1'b0;
      wbyte_reg   <= '0;
      wlane_reg   <= 1'b0;
      w_full_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      awaddr_reg  <= awaddr_next;
      aw_full_reg <= aw_full_next;
      wbyte_reg   <= wbyte_next;
      wlane_reg   <= wlane_next;
      w_full_reg  <= w_full_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // control register and count field

  logic               active_reg;
  logic               active_next;
  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] count_next;
  logic               tick;
  logic               active_eff;
  logic               trip_count;
  logic               trip_soft;
  logic               trip_halt;
  logic               trigger;

  wwt_prescaler #(
    .DIV     (PRESCALE)
  ) u_prescaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  assign active_eff = active_reg || hw_watchdog_option;

  always_comb begin
    active_next = active_reg;
    count_next  = count_reg;
    if (wr_ctrl) begin
      // the prescaler is not restarted, so the first step may come early
      count_next = wbyte_reg[COUNT_W-1:0];
      if (wbyte_reg[ACTIVE_BIT]) begin
        active_next = 1'b1;
      end
    end else if (tick) begin
      count_next = count_reg - COUNT_W'(1);
    end
  end

  // a roll from 40h to 3Fh, only through a prescaler step
  assign trip_count = active_eff && !wr_ctrl && tick && (count_reg == COUNT_TRIP);
  // software reset: a write with the count msb clear that arms the watchdog or finds it already armed
  assign trip_soft  = wr_ctrl && (wbyte_reg[ACTIVE_BIT] || active_eff)
                      && !wbyte_reg[COUNT_MSB_BIT];
  assign trip_halt  = halt_request && active_eff && halt_reset_option;
  assign trigger    = trip_count || trip_soft || trip_halt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_reg <= CTRL_RESET[ACTIVE_BIT];
      count_reg  <= CTRL_RESET[COUNT_W-1:0];
    end else begin
      active_reg <= active_next;
      count_reg  <= count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencer: pin pulse, then the reset phase

  wwt_seq_t           seq_reg;
  wwt_seq_t           seq_next;
  logic               tmr_load;
  logic [TIMER_W-1:0] tmr_len;
  logic               tmr_busy;
  logic               tmr_done;
  logic               pin_oe_reg;
  logic               pin_oe_next;
  logic               phase_reg;
  logic               phase_next;
  logic               halt_enter_reg;
  logic               halt_enter_next;

  wwt_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (tmr_load),
    .len     (tmr_len),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  always_comb begin
    seq_next = seq_reg;
    tmr_load = 1'b0;
    tmr_len  = TIMER_W'(PIN_LOW);
    case (seq_reg)
      SEQ_IDLE: begin
        if (trigger) begin
          tmr_load = 1'b1;
          seq_next = SEQ_PIN;
        end
      end
      SEQ_PIN: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_len  = long_reset_phase ? TIMER_W'(PHASE_LONG_CYCLES)
                                      : TIMER_W'(PHASE_SHORT_CYCLES);
          seq_next = SEQ_PHASE;
        end
      end
      SEQ_PHASE: begin
        if (tmr_done) begin
          seq_next = SEQ_IDLE;
        end
      end
      default: begin
        seq_next = SEQ_IDLE;
      end
    endcase
    pin_oe_next     = (seq_next == SEQ_PIN);
    phase_next      = (seq_next == SEQ_PHASE);
    // a halt that resets never enters halt
    halt_enter_next = halt_request && !trip_halt && (seq_reg == SEQ_IDLE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_reg        <= SEQ_IDLE;
      pin_oe_reg     <= 1'b0;
      phase_reg      <= 1'b0;
      halt_enter_reg <= 1'b0;
    end else begin
      seq_reg        <= seq_next;
      pin_oe_reg     <= pin_oe_next;
      phase_reg      <= phase_next;
      halt_enter_reg <= halt_enter_next;
    end
  end

  // open-drain reset pin: only ever pulled low
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe  = pin_oe_reg;
  assign reset_phase   = phase_reg;
  assign halt_enter    = halt_enter_reg;

  ////////////////////////////////////////////////////////////////////////////
  // bus read channel: one cycle from address to data

  logic                  rvalid_reg;
  logic                  rvalid_next;
  logic [AXI_DATA_W-1:0] rdata_reg;
  logic [AXI_DATA_W-1:0] rdata_next;
  logic [1:0]            rresp_reg;
  logic [1:0]            rresp_next;
  logic [7:0]            status_byte;

  assign s_axi_arready = !rvalid_reg;

  always_comb begin
    status_byte                = '0;
    status_byte[ST_ACTIVE_BIT] = active_eff;
    status_byte[ST_HW_BIT]     = hw_watchdog_option;
    status_byte[ST_HALT_BIT]   = halt_reset_option;
    status_byte[ST_BUSY_BIT]   = tmr_busy;
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rdata_next  = '0;
      rresp_next  = RESP_OKAY;
      if (s_axi_araddr[AXI_ADDR_W-1:2] == CTRL_INDEX) begin
        rdata_next[7:0] = {active_reg, count_reg};
      end else if (s_axi_araddr[AXI_ADDR_W-1:2] == STATUS_INDEX) begin
        rdata_next[7:0] = status_byte;
      end else begin
        rresp_next = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

endmodule : wwt_top

//--- testbench/wwt_top_asserts.sv
// port checker for the watchdog top: bus answers, reset sequence, halt handling
// assumes it is bound into wwt_top and sees only that module's ports
`timescale 1ns/10ps
module wwt_top_asserts
  import wwt_pkg::*;
#(
  parameter int unsigned PRESCALE = PRESCALE_CYCLES,
  parameter int unsigned PIN_LOW  = PIN_LOW_CYCLES
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        hw_watchdog_option,
  input wire logic        halt_reset_option,
  input wire logic        long_reset_phase,
  input wire logic        halt_request,
  input wire logic        halt_enter,
  input wire logic        reset_pin_oe,
  input wire logic        reset_phase
);
  logic [7:0]  aw_reg, aw_next;
  logic [8:0]  wd_reg, wd_next;
  logic        act_reg, act_next, hit;
  logic [15:0] pin_reg, pin_next, ph_reg, ph_next;

  assign hit = wd_reg[8] && aw_reg == {CTRL_INDEX, 2'b00};
  always_comb begin
    aw_next  = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_reg;
    wd_next  = (s_axi_wvalid && s_axi_wready) ? {s_axi_wstrb[0], s_axi_wdata[7:0]} : wd_reg;
    act_next = act_reg || (s_axi_bvalid && s_axi_bready && hit && wd_reg[7]);
    pin_next = reset_pin_oe ? pin_reg + 16'h1 : 16'h0;
    ph_next  = reset_phase ? ph_reg + 16'h1 : 16'h0;
  end
  // counters restart with the design, so a pulse cut short by reset is never judged
  always_ff @(posedge aclk) begin
    aw_reg <= aw_next;
    wd_reg <= wd_next;
    if (!aresetn) begin
      act_reg <= 1'b0;
      pin_reg <= 16'h0;
      ph_reg  <= 16'h0;
    end else begin
      act_reg <= act_next;
      pin_reg <= pin_next;
      ph_reg  <= ph_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence trip_s;
    ##[0:2] (reset_pin_oe || reset_phase);
  endsequence
  sequence halt_conv_s;
    halt_request && halt_reset_option && (act_reg || hw_watchdog_option);
  endsequence

  a_sw_reset: assert property (
    $rose(s_axi_bvalid) && s_axi_bresp == RESP_OKAY && hit && wd_reg[7:6] == 2'b10 |-> trip_s
  ) else $error("software reset write did not start a reset");
  a_halt_reset: assert property (
    halt_conv_s |-> ##[1:2] (reset_pin_oe || reset_phase)
  ) else $error("halt with watchdog active did not start a reset");
  a_halt_block: assert property (
    halt_conv_s |=> !halt_enter
  ) else $error("halt entered although it was turned into a reset");
  a_halt_pass: assert property (
    halt_request && !halt_reset_option && !reset_pin_oe && !reset_phase |=> halt_enter
  ) else $error("plain halt request not passed on");
  a_pin_len: assert property (
    $past(aresetn) && $fell(reset_pin_oe) |-> pin_reg == PIN_LOW && reset_phase
  ) else $error("reset pin pulse has the wrong length");
  a_phase_len: assert property (
    $past(aresetn) && $fell(reset_phase) |->
      ph_reg == (long_reset_phase ? PHASE_LONG_CYCLES : PHASE_SHORT_CYCLES)
  ) else $error("reset phase has the wrong length");
  a_seq_excl: assert property (
    !(reset_pin_oe && reset_phase)
  ) else $error("pin pulse and reset phase overlap");
  a_read_busy: assert property (
    s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == 24'h0
  ) else $error("read answer malformed or new read accepted");
endmodule : wwt_top_asserts

bind wwt_top wwt_top_asserts #(.PRESCALE(PRESCALE), .PIN_LOW(PIN_LOW)) u_chk (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .hw_watchdog_option, .halt_reset_option, .long_reset_phase,
  .halt_request, .halt_enter, .reset_pin_oe, .reset_phase
);

//--- testbench/wwt_sysrst_model.sv
// system reset side: pulled-up reset pin and a monitor of the reset sequence
// assumes only the watchdog pulls the pin, through its open-drain enable
`timescale 1ns/10ps
module wwt_sysrst_model (
  input  wire logic aclk,
  input  wire logic reset_pin_out,
  input  wire logic reset_pin_oe,
  input  wire logic reset_phase,
  output logic      pin_level,
  output int        low_len,
  output int        phase_len
);
  int lo_cnt;
  int ph_cnt;

  // board pull-up: the pin reads high whenever the watchdog lets go
  assign pin_level = reset_pin_oe ? reset_pin_out : 1'b1;
  // lengths are latched on the first edge after each pulse, so the bench reads them an edge later
  always @(posedge aclk) begin
    if (pin_level === 1'b0) begin
      lo_cnt <= lo_cnt + 1;
    end else if (lo_cnt > 0) begin
      low_len <= lo_cnt;
      lo_cnt  <= 0;
    end
    if (reset_phase === 1'b1) begin
      ph_cnt <= ph_cnt + 1;
    end else if (ph_cnt > 0) begin
      phase_len <= ph_cnt;
      ph_cnt    <= 0;
    end
  end
endmodule : wwt_sysrst_model

//--- testbench/tb_top.sv
// self-checking bench for wwt_top with small prescale and pin counts
// assumes the checker is bound in and the reset-side model is instantiated here
`timescale 1ns/10ps
module tb_top
  import wwt_pkg::*;
;
  localparam int         PS = 8;
  localparam int         PL = 4;
  localparam logic [7:0] CA = {CTRL_INDEX, 2'b00};
  typedef struct { logic [7:0] d; int w; logic [6:0] hi; } wwt_row_t;

  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, hw_watchdog_option, halt_reset_option, long_reset_phase;
  logic        halt_request, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, halt_enter, reset_pin_out, reset_pin_oe, reset_phase, pin_level;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          low_len, phase_len, err_count, comparisons;
  wwt_row_t    rows [4] = '{'{8'h55, 0, 7'h55}, '{8'h50, 40, 7'h4B}, '{8'h00, 8, 7'h7F},
                            '{8'h20, 0, 7'h20}};

  wwt_top #(.PRESCALE(PS), .PIN_LOW(PL)) dut (
    .s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'hF), .*
  );
  wwt_sysrst_model u_sys (.*);

  ////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task chk_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
    comparisons++;
    if ((^g) === 1'bx || g < lo || g > hi) begin
      err_count++;
      $display("wrong value %s expected %0d to %0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng

  // one transfer; each channel is dropped at its own handshake
  task bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    if (we) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (we ? s_axi_bvalid : s_axi_rvalid) break;
    end
    q = s_axi_rdata;
    r = we ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (n == 50) begin
      err_count++;
      end_of_test();
    end
  endtask : bus

  task after_reset;
    aresetn <= 1'b1;
    bus(1'b0, CA, 8'h00);
    chk("control after reset", 32'h7F, q);
  endtask : after_reset

  task fire(input int lo, input int hi, input int ph);
    int n;
    n = 0;
    while (pin_level !== 1'b0 && n <= hi) begin
      @(posedge aclk);
      n++;
    end
    chk_rng("trip time", lo, hi, n);
    if (n > hi) end_of_test();
    n = 0;
    while ((reset_pin_oe !== 1'b0 || reset_phase !== 1'b0) && n < 5000) begin
      @(posedge aclk);
      n++;
    end
    @(posedge aclk);
    chk("pin low cycles", PL, low_len);
    chk("phase cycles", ph, phase_len);
    if (n == 5000) begin
      err_count++;
      end_of_test();
    end
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    after_reset();
  endtask : fire

  task halt_pulse(input logic exp);
    @(posedge aclk);
    halt_request <= 1'b1;
    @(posedge aclk);
    halt_request <= 1'b0;
    @(posedge aclk);
    chk("halt enter", 32'(exp), 32'(halt_enter));
  endtask : halt_pulse

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {hw_watchdog_option, halt_reset_option, long_reset_phase, halt_request} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    err_count = 0;
    comparisons = 0;
    repeat (2) @(posedge aclk);
    after_reset();
    bus(1'b0, 8'h40, 8'h00);
    chk("unmapped read resp", 32'(RESP_SLVERR), 32'(r));
    bus(1'b1, {STATUS_INDEX, 2'b00}, 8'hFF);
    chk("status write resp", 32'(RESP_SLVERR), 32'(r));
    foreach (rows[i]) begin
      bus(1'b1, CA, rows[i].d);
      repeat (rows[i].w) @(posedge aclk);
      bus(1'b0, CA, 8'h00);
      chk("active bit", 32'h0, 32'(q[7]));
      chk_rng("count", rows[i].hi - 1, rows[i].hi, 32'(q[6:0]));
    end
    chk("pin idle", 32'h1, 32'(pin_level));
    bus(1'b1, CA, 8'hF0);
    chk("control write resp", 32'(RESP_OKAY), 32'(r));
    bus(1'b1, CA, 8'h75);
    bus(1'b0, CA, 8'h00);
    chk("active kept", 32'h1, 32'(q[7]));
    bus(1'b1, CA, 8'hFF);
    fire(63 * PS - 2, 64 * PS + 3, 256);
    long_reset_phase <= 1'b1;
    bus(1'b1, CA, 8'hBF);
    fire(0, 4, 4096);
    long_reset_phase <= 1'b0;
    halt_reset_option <= 1'b1;
    bus(1'b1, CA, 8'hC5);
    halt_pulse(1'b0);
    fire(0, 4, 256);
    halt_reset_option <= 1'b0;
    bus(1'b1, CA, 8'hC5);
    bus(1'b1, CA, 8'hFF);
    halt_pulse(1'b1);
    chk("pin after halt", 32'h1, 32'(pin_level));
    // hardware mode starts from a cleared activation bit, so the option alone must arm it
    hw_watchdog_option <= 1'b1;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    after_reset();
    bus(1'b0, {STATUS_INDEX, 2'b00}, 8'h00);
    chk("status in hw mode", 32'h3, q);
    bus(1'b1, CA, 8'h41);
    fire(PS - 2, 2 * PS + 3, 256);
    end_of_test();
  end
endmodule : tb_top
